// *** ebwc_ctrl.sv ***
`timescale 1ns/1ns
module ebwc_ctrl
  import ebwc_pkg::*;
#(
  parameter logic [3:0] REF_HALF_PERIOD = REF_HALF_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic single_chip_in,
  input wire logic [4:0] addr_width_in,
  input wire logic [2:0] seg_lines_in,
  input wire logic [CFG_W-1:0] default_timing_config_in,
  input wire logic [CFG_W-1:0] default_function_config_in,
  input wire logic [NUM_WIN-1:0][CFG_W-1:0] window_timing_config_in,
  input wire logic [NUM_WIN-1:0][CFG_W-1:0] window_function_config_in,
  input wire logic [NUM_WIN-1:0][CFG_W-1:0] window_address_select_in,
  input wire logic req_valid_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic req_write_in,
  input wire logic req_byte_in,
  input wire logic [DATA_W-1:0] req_wdata_in,
  output logic req_ready_out,
  output logic resp_done_out,
  output logic resp_error_out,
  output logic [DATA_W-1:0] resp_rdata_out,
  output logic bus_reference_clock_out,
  output logic [ADDR_W-1:0] ext_addr_out,
  input wire logic [DATA_W-1:0] ext_ad_in,
  output logic [DATA_W-1:0] ext_ad_out,
  output logic [DATA_W-1:0] ext_ad_oe_out,
  output logic ext_ale_out,
  output logic ext_rd_n_out,
  output logic ext_wr_n_out,
  output logic [1:0] ext_byte_en_n_out,
  output logic [NUM_WIN:0] ext_cs_n_out,
  input wire logic ext_ready_in,
  output logic lpb_sel_out,
  output logic lpb_write_out,
  output logic [ADDR_W-1:0] lpb_addr_out,
  output logic [DATA_W-1:0] lpb_wdata_out,
  input wire logic [DATA_W-1:0] lpb_rdata_in,
  input wire logic lpb_ready_in
);

  ebwc_state_type state;
  ebwc_state_type next_state;
  logic [3:0] div_cnt;
  logic div_wrap;
  logic bus_rise;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic rdy_s1;
  logic rdy_s2;
  logic rdy_s3;
  logic rdy_level;
  logic [DATA_W-1:0] ad_s1;
  logic [DATA_W-1:0] ad_s2;
  logic [DATA_W-1:0] ad_s3;
  logic [NUM_WIN-1:0] win_hits;
  logic [2:0] req_region;
  logic [CFG_W-1:0] req_tcfg;
  logic [CFG_W-1:0] req_fcfg;
  logic req_lpb;
  logic req_io;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic cur_write;
  logic next_write;
  logic cur_byte;
  logic next_byte;
  logic [DATA_W-1:0] cur_wdata;
  logic [DATA_W-1:0] next_wdata;
  logic cur_lpb;
  logic next_lpb;
  logic cur_io;
  logic next_io;
  logic [2:0] cur_region;
  logic [2:0] next_region;
  logic [CFG_W-1:0] cur_tcfg;
  logic [CFG_W-1:0] next_tcfg;
  logic [CFG_W-1:0] cur_fcfg;
  logic [CFG_W-1:0] next_fcfg;
  logic cur_hi;
  logic next_hi;
  logic next_done;
  logic next_err;
  logic [DATA_W-1:0] next_rdata;
  logic finish;
  logic need_ready;
  logic ready_ok;
  logic cur_wide;
  logic lane_hi;
  logic [ADDR_W-1:0] addr_mask;
  logic [ADDR_W-1:0] bus_addr;
  logic ext_active;
  logic data_phase;
  logic next_wide;
  logic next_lane;

  // reference clock: core clock divided, bus steps on its rising edge
  assign div_wrap = (div_cnt == REF_HALF_PERIOD - 4'h1);
  assign bus_rise = div_wrap && !bus_reference_clock_out;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt <= 4'h0;
      bus_reference_clock_out <= 1'b0;
    end else if (div_wrap) begin
      div_cnt <= 4'h0;
      bus_reference_clock_out <= ~bus_reference_clock_out;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // pin inputs: three stages; ready level taken once stages two and three agree
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      rdy_s3 <= 1'b0;
      rdy_level <= 1'b0;
    end else begin
      rdy_s1 <= ext_ready_in;
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      if (rdy_s2 == rdy_s3) begin
        rdy_level <= rdy_s3;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ad_s1 <= RESET_DATA;
      ad_s2 <= RESET_DATA;
      ad_s3 <= RESET_DATA;
    end else begin
      ad_s1 <= ext_ad_in;
      ad_s2 <= ad_s1;
      ad_s3 <= ad_s2;
    end
  end

  // window decoders
  ebwc_win_if win_bus[NUM_WIN]();

  for (genvar i = 0; i < NUM_WIN; i++) begin : g_win
    assign win_bus[i].addr = req_addr_in;
    assign win_bus[i].select = window_address_select_in[i];
    assign win_bus[i].enable = window_function_config_in[i][FCFG_EN_POS];
    assign win_hits[i] = win_bus[i].hit;
    ebwc_window_match u_match (
      .win(win_bus[i])
    );
  end

  always_comb begin
    req_region = 3'h0;
    for (int i = 0; i < NUM_WIN; i++) begin
      if (win_hits[i]) begin
        req_region = 3'(i + 1);
      end
    end
  end

  always_comb begin
    if (req_region == 3'h0) begin
      req_tcfg = default_timing_config_in;
      req_fcfg = default_function_config_in;
    end else begin
      req_tcfg = window_timing_config_in[2'(req_region - 3'h1)];
      req_fcfg = window_function_config_in[2'(req_region - 3'h1)];
    end
  end

  // 256 segments of 64K; reserved areas fall through to the external bus
  assign req_lpb = (req_addr_in[23:16] == LPB_SEGMENT) &&
                   (req_addr_in[15:12] <= LPB_LAST_NIBBLE);
  assign req_io = (req_addr_in >= IO_FIRST) && (req_addr_in <= IO_LAST);

  assign cur_wide = cur_lpb || cur_fcfg[FCFG_WIDE_POS];
  assign lane_hi = cur_addr[0] || cur_hi;
  assign need_ready = cur_lpb || cur_fcfg[FCFG_RDY_EN_POS];
  assign ready_ok = cur_lpb ? lpb_ready_in :
                    (rdy_level == cur_fcfg[FCFG_RDY_HIGH_POS]);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_addr = cur_addr;
    next_write = cur_write;
    next_byte = cur_byte;
    next_wdata = cur_wdata;
    next_lpb = cur_lpb;
    next_io = cur_io;
    next_region = cur_region;
    next_tcfg = cur_tcfg;
    next_fcfg = cur_fcfg;
    next_hi = cur_hi;
    next_done = 1'b0;
    next_err = 1'b0;
    next_rdata = resp_rdata_out;
    finish = 1'b0;
    case (state)
      ST_IDLE: begin
        if (bus_rise && req_valid_in) begin
          next_addr = req_addr_in;
          next_write = req_write_in;
          next_byte = req_byte_in;
          next_wdata = req_wdata_in;
          next_lpb = req_lpb;
          next_io = req_io;
          next_region = req_region;
          next_tcfg = req_tcfg;
          next_fcfg = req_fcfg;
          next_hi = 1'b0;
          if (single_chip_in && !req_lpb) begin
            next_err = 1'b1;
          end else begin
            next_state = ST_ADDR;
            next_cnt = req_lpb ? 4'h0 : {2'b00, req_tcfg[TCFG_ADDR_POS +: TCFG_ADDR_W]};
          end
        end
      end
      ST_ADDR: begin
        if (bus_rise) begin
          if (cnt == 4'h0) begin
            next_state = ST_CMD;
            next_cnt = cur_lpb ? 4'h0 : cur_tcfg[TCFG_CMD_POS +: TCFG_CMD_W];
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
      end
      ST_CMD: begin
        if (bus_rise) begin
          if (cnt != 4'h0) begin
            next_cnt = cnt - 4'h1;
          end else if (need_ready && !ready_ok) begin
            next_state = ST_WAIT;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (bus_rise && ready_ok) begin
          finish = 1'b1;
        end
      end
      ST_RECOV: begin
        if (bus_rise) begin
          if (cnt == 4'h0) begin
            next_state = ST_IDLE;
            next_done = cur_io;
          end else begin
            next_cnt = cnt - 4'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (finish) begin
      if (!cur_write) begin
        if (cur_lpb) begin
          next_rdata = lpb_rdata_in;
        end else if (cur_wide) begin
          next_rdata = ad_s3;
        end else if (lane_hi) begin
          next_rdata = {ad_s3[7:0], resp_rdata_out[7:0]};
        end else begin
          next_rdata = {resp_rdata_out[15:8], ad_s3[7:0]};
        end
      end
      if (!cur_wide && !cur_byte && !cur_hi) begin
        // word on 8-bit bus: second access for the high byte
        next_hi = 1'b1;
        next_state = ST_ADDR;
        next_cnt = {2'b00, cur_tcfg[TCFG_ADDR_POS +: TCFG_ADDR_W]};
      end else begin
        next_state = ST_RECOV;
        next_cnt = cur_lpb ? 4'h0 : {2'b00, cur_tcfg[TCFG_RECOV_POS +: TCFG_RECOV_W]};
        next_done = !cur_io;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      req_ready_out <= 1'b0;
      resp_done_out <= 1'b0;
      resp_error_out <= 1'b0;
      resp_rdata_out <= RESET_DATA;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      req_ready_out <= (next_state == ST_IDLE);
      resp_done_out <= next_done;
      resp_error_out <= next_err;
      resp_rdata_out <= next_rdata;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur_addr <= RESET_ADDR;
      cur_write <= 1'b0;
      cur_byte <= 1'b0;
      cur_wdata <= RESET_DATA;
      cur_lpb <= 1'b0;
      cur_io <= 1'b0;
      cur_region <= 3'h0;
      cur_tcfg <= 16'h0000;
      cur_fcfg <= 16'h0000;
      cur_hi <= 1'b0;
    end else begin
      cur_addr <= next_addr;
      cur_write <= next_write;
      cur_byte <= next_byte;
      cur_wdata <= next_wdata;
      cur_lpb <= next_lpb;
      cur_io <= next_io;
      cur_region <= next_region;
      cur_tcfg <= next_tcfg;
      cur_fcfg <= next_fcfg;
      cur_hi <= next_hi;
    end
  end

  // driven address bits: width limit and segment line limit
  always_comb begin
    addr_mask = 24'h000000;
    for (int i = 0; i < ADDR_W; i++) begin
      if ((5'(i) < addr_width_in) && (5'(i) < MAX_ADDR_BITS) &&
          ((i < SEG_BASE_BIT) || (i < SEG_BASE_BIT + int'(seg_lines_in)))) begin
        addr_mask[i] = 1'b1;
      end
    end
  end

  assign bus_addr = {next_addr[23:1], next_addr[0] | next_hi};
  assign ext_active = !next_lpb &&
                      ((next_state == ST_ADDR) || (next_state == ST_CMD) ||
                       (next_state == ST_WAIT));
  assign data_phase = (next_state == ST_CMD) || (next_state == ST_WAIT);
  assign next_wide = next_fcfg[FCFG_WIDE_POS];
  assign next_lane = next_addr[0] || next_hi;

  // pins follow the next state so they change on the reference rising edge
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_addr_out <= RESET_ADDR;
      ext_ad_out <= RESET_DATA;
      ext_ad_oe_out <= 16'h0000;
      ext_ale_out <= 1'b0;
      ext_rd_n_out <= 1'b1;
      ext_wr_n_out <= 1'b1;
      ext_byte_en_n_out <= 2'h3;
      ext_cs_n_out <= RESET_CS_N;
    end else if (!ext_active) begin
      ext_ale_out <= 1'b0;
      ext_rd_n_out <= 1'b1;
      ext_wr_n_out <= 1'b1;
      ext_ad_oe_out <= 16'h0000;
      ext_byte_en_n_out <= 2'h3;
      ext_cs_n_out <= RESET_CS_N;
    end else begin
      if (next_fcfg[FCFG_MUX_POS]) begin
        ext_addr_out <= {bus_addr[23:16], 16'h0000} & addr_mask;
      end else begin
        ext_addr_out <= bus_addr & addr_mask;
      end
      ext_ale_out <= (next_state == ST_ADDR);
      ext_rd_n_out <= !(data_phase && !next_write);
      ext_wr_n_out <= !(data_phase && next_write);
      if ((next_state == ST_ADDR) && next_fcfg[FCFG_MUX_POS]) begin
        ext_ad_out <= bus_addr[15:0] & addr_mask[15:0];
        ext_ad_oe_out <= 16'hFFFF;
      end else if (data_phase && next_write) begin
        if (next_wide) begin
          ext_ad_out <= next_wdata;
          ext_ad_oe_out <= 16'hFFFF;
        end else begin
          ext_ad_out <= {8'h00, next_lane ? next_wdata[15:8] : next_wdata[7:0]};
          ext_ad_oe_out <= 16'h00FF;
        end
      end else begin
        ext_ad_oe_out <= 16'h0000;
      end
      if (!next_wide) begin
        ext_byte_en_n_out <= 2'h2;
      end else if (next_byte) begin
        ext_byte_en_n_out <= next_addr[0] ? 2'h1 : 2'h2;
      end else begin
        ext_byte_en_n_out <= 2'h0;
      end
      if (next_fcfg[FCFG_EN_POS]) begin
        ext_cs_n_out <= ~(5'h01 << next_region);
      end else begin
        ext_cs_n_out <= RESET_CS_N;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lpb_sel_out <= 1'b0;
      lpb_write_out <= 1'b0;
      lpb_addr_out <= RESET_ADDR;
      lpb_wdata_out <= RESET_DATA;
    end else begin
      lpb_sel_out <= next_lpb && data_phase;
      lpb_write_out <= next_lpb && data_phase && next_write;
      lpb_addr_out <= next_addr;
      lpb_wdata_out <= next_wdata;
    end
  end

endmodule

// *** ebwc_ctrl_chk.sv ***
`timescale 1ns/1ns
module ebwc_ctrl_chk
  import ebwc_pkg::*;
#(
  parameter logic [3:0] REF_HALF_PERIOD = REF_HALF_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic single_chip_in,
  input wire logic [4:0] addr_width_in,
  input wire logic req_valid_in,
  input wire logic resp_error_out,
  input wire logic bus_reference_clock_out,
  input wire logic [ADDR_W-1:0] ext_addr_out,
  input wire logic ext_ale_out,
  input wire logic ext_rd_n_out,
  input wire logic ext_wr_n_out,
  input wire logic [1:0] ext_byte_en_n_out,
  input wire logic [NUM_WIN:0] ext_cs_n_out,
  input wire logic lpb_sel_out,
  input wire logic lpb_ready_in
);
  logic ref_q;
  logic [3:0] hcnt;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // cycles since the reference clock last changed
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_q <= 1'b1;
      hcnt <= 4'h0;
    end else begin
      ref_q <= bus_reference_clock_out;
      hcnt <= (bus_reference_clock_out != ref_q) ? 4'h0 : hcnt + 4'h1;
    end
  end
  a_ref_half_period: assert property (hcnt < REF_HALF_PERIOD)
    else $error("reference clock half period too long");
  a_pins_on_rise: assert property (($changed(ext_rd_n_out) || $changed(ext_wr_n_out) ||
    $changed(ext_cs_n_out) || $changed(ext_ale_out)) |-> $rose(bus_reference_clock_out))
    else $error("bus pin changed off a reference rise");
  a_error_quiet: assert property (resp_error_out |-> $past(single_chip_in) &&
    $past(req_valid_in) && ext_cs_n_out == 5'h1F && ext_rd_n_out)
    else $error("refusal without single-chip mode or with bus activity");
  a_one_select: assert property ($onehot0(~ext_cs_n_out))
    else $error("more than one chip select active");
  a_strobe_excl: assert property (ext_rd_n_out || ext_wr_n_out)
    else $error("read and write strobes both active");
  a_strobe_lanes: assert property (!(ext_rd_n_out && ext_wr_n_out) |->
    ext_byte_en_n_out != 2'h3)
    else $error("strobe without a byte lane");
  a_addr_width: assert property (ext_ale_out |-> (ext_addr_out >> addr_width_in) == 24'h000000)
    else $error("address bit above programmed width driven");
  a_lpb_quiet: assert property (lpb_sel_out |-> ext_cs_n_out == 5'h1F && ext_rd_n_out &&
    ext_wr_n_out && !ext_ale_out)
    else $error("external pins active during local bus access");
  a_lpb_hold: assert property (lpb_sel_out && !lpb_ready_in |=> lpb_sel_out)
    else $error("local access ended without ready");
  c_refused: cover property (resp_error_out);
  c_local: cover property (lpb_sel_out && lpb_ready_in);
  c_win4: cover property ($rose(ext_ale_out) && !ext_cs_n_out[4]);
endmodule
bind ebwc_ctrl ebwc_ctrl_chk #(.REF_HALF_PERIOD(REF_HALF_PERIOD)) i_chk (.*);

// *** ebwc_ext_mem.sv ***
`timescale 1ns/1ns
module ebwc_ext_mem (
  input wire logic ref_clk_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] ad_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [1:0] be_n_in,
  input wire logic [4:0] cs_n_in,
  input wire logic rdy_high_in,
  input wire logic [3:0] rdy_dly_in,
  output logic [15:0] ad_out,
  output logic ready_out
);
  logic [15:0] mem [0:255];
  logic [15:0] lo;
  logic [15:0] last = 16'hA5C3;
  logic [3:0] cnt;
  logic [7:0] b;
  logic rd;
  // device launches on the rising edge, so sample mid-period
  always @(negedge ref_clk_in) begin
    if (ale_in) begin
      lo <= cs_n_in[4] ? addr_in[15:0] : ad_in;
    end
    cnt <= (rd_n_in && wr_n_in) ? 4'h0 : cnt + 4'h1;
    if (!wr_n_in && be_n_in == 2'h2 && lo[0]) begin
      mem[lo[8:1]][15:8] <= ad_in[7:0];
    end
    if (!wr_n_in && be_n_in == 2'h2 && !lo[0]) begin
      mem[lo[8:1]][7:0] <= ad_in[7:0];
    end
    if (!wr_n_in && be_n_in == 2'h1) begin
      mem[lo[8:1]][15:8] <= ad_in[15:8];
    end
    if (!wr_n_in && be_n_in == 2'h0) begin
      mem[lo[8:1]] <= ad_in;
    end
    if (rd) begin
      last <= ad_out;
    end
  end
  assign rd = !rd_n_in && cs_n_in != 5'h1F;
  assign b = lo[0] ? mem[lo[8:1]][15:8] : mem[lo[8:1]][7:0];
  // released bus shows the inverse of the last value
  assign ad_out = !rd ? ~last : (be_n_in == 2'h2 ? {b, b} : mem[lo[8:1]]);
  assign ready_out = (cnt >= rdy_dly_in) ? rdy_high_in : !rdy_high_in;
endmodule

// *** ebwc_pkg.sv ***
// Contract
// - single-chip mode or external bus mode
// - driven address bits programmable zero to 24
// - external data bus eight or sixteen bits
// - demultiplexed low address on dedicated lines
// - segment lines limit space 64K to 8M
// - one chip select per window plus default
// - bus timing programmable per region
// - ready input with selectable active level
// - four windows with own bus characteristics
// - window 4 over 3, 2 over 1
// - outside all windows uses default region
// - governing window asserts its chip select
// - bus timing on reference clock rising edge
// - bus mode switches per window hit
// - reserved areas become external bus accesses
// - external IO area accesses strictly ordered
// - 16M space, 256 segments, 16K pages
// - byte and word access everywhere; local bus has no byte select, so byte writes go out as full words
// - local peripheral bus served like external
// - reference clock output from system clock
package ebwc_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CFG_W = 16;
  localparam int NUM_WIN = 4;

  // timing config fields
  localparam int TCFG_ADDR_POS = 0;
  localparam int TCFG_ADDR_W = 2;
  localparam int TCFG_CMD_POS = 2;
  localparam int TCFG_CMD_W = 4;
  localparam int TCFG_RECOV_POS = 6;
  localparam int TCFG_RECOV_W = 2;

  // function config bits
  localparam int FCFG_EN_POS = 0;
  localparam int FCFG_RDY_EN_POS = 1;
  localparam int FCFG_RDY_HIGH_POS = 2;
  localparam int FCFG_WIDE_POS = 3;
  localparam int FCFG_MUX_POS = 4;

  // address select fields: base is A23..A12, size code widens the block
  localparam int ASEL_SIZE_POS = 0;
  localparam int ASEL_SIZE_W = 4;
  localparam int ASEL_BASE_POS = 4;
  localparam int ASEL_BASE_W = 12;

  // address map
  localparam logic [7:0] LPB_SEGMENT = 8'h20;
  localparam logic [3:0] LPB_LAST_NIBBLE = 4'hB;
  localparam logic [23:0] IO_FIRST = 24'h210000;
  localparam logic [23:0] IO_LAST = 24'h3FFFFF;
  localparam logic [4:0] MAX_ADDR_BITS = 5'h18;
  localparam int SEG_BASE_BIT = 16;

  // reference clock divider: core cycles per half period
  localparam logic [3:0] REF_HALF_DEFAULT = 4'h1;

  // reset values
  localparam logic [15:0] RESET_DATA = 16'h0000;
  localparam logic [23:0] RESET_ADDR = 24'h000000;
  localparam logic [4:0] RESET_CS_N = 5'h1F;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_CMD = 3'b010,
    ST_WAIT = 3'b011,
    ST_RECOV = 3'b100
  } ebwc_state_type;

endpackage

// *** ebwc_win_if.sv ***
`timescale 1ns/1ns
interface ebwc_win_if;
  logic [23:0] addr;
  logic [15:0] select;
  logic enable;
  logic hit;
  modport decoder(input addr, input select, input enable, output hit);
  modport ctrl(output addr, output select, output enable, input hit);
endinterface

// *** ebwc_window_match.sv ***
`timescale 1ns/1ns
module ebwc_window_match
  import ebwc_pkg::*;
(
  ebwc_win_if.decoder win
);

  logic [ASEL_BASE_W-1:0] mask;
  logic [ASEL_BASE_W-1:0] base;

  always_comb begin
    base = win.select[ASEL_BASE_POS +: ASEL_BASE_W];
    mask = 12'hFFF << win.select[ASEL_SIZE_POS +: ASEL_SIZE_W];
  end

  // block of 4K << size, aligned on base
  assign win.hit = win.enable && (((win.addr[23:12] ^ base) & mask) == 12'h000);

endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic core_clk_in, nrst_in, single_chip_in, req_valid_in, req_write_in, req_byte_in;
  logic ext_ready_in, lpb_ready_in, req_ready_out, resp_done_out, resp_error_out;
  logic bus_reference_clock_out, ext_ale_out, ext_rd_n_out, ext_wr_n_out, lpb_sel_out;
  logic lpb_write_out, rdy_hi, stb_q, got_err;
  logic [4:0] addr_width_in, ext_cs_n_out, cs_acc;
  logic [2:0] seg_lines_in, lsh;
  logic [1:0] ext_byte_en_n_out, be_acc;
  logic [3:0] rdy_dly;
  logic [15:0] default_timing_config_in, default_function_config_in, req_wdata_in;
  logic [15:0] resp_rdata_out, ext_ad_in, ext_ad_out, ext_ad_oe_out, lpb_wdata_out;
  logic [15:0] lpb_rdata_in, mdl_ad, rdat, al_ad;
  logic [3:0][15:0] window_timing_config_in, window_function_config_in;
  logic [3:0][15:0] window_address_select_in;
  logic [23:0] req_addr_in, ext_addr_out, lpb_addr_out, al_addr;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc, nst, t0;
  ebwc_ctrl #(.REF_HALF_PERIOD(4'h4)) i_dut (.*);
  ebwc_ext_mem i_mem (.ref_clk_in(bus_reference_clock_out), .addr_in(ext_addr_out),
    .ad_in(ext_ad_in), .ale_in(ext_ale_out), .rd_n_in(ext_rd_n_out), .wr_n_in(ext_wr_n_out),
    .be_n_in(ext_byte_en_n_out), .cs_n_in(ext_cs_n_out), .rdy_high_in(rdy_hi),
    .rdy_dly_in(rdy_dly), .ad_out(mdl_ad), .ready_out(ext_ready_in));
  assign ext_ad_in = (ext_ad_oe_out & ext_ad_out) | (~ext_ad_oe_out & mdl_ad);
  assign lpb_ready_in = lsh[2];
  assign lpb_rdata_in = lpb_ready_in ? 16'h0F1E : 16'hF0E1;
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  always @(negedge core_clk_in) lsh <= {lsh[1:0], lpb_sel_out};
  always @(posedge core_clk_in) begin
    stb_q <= ext_rd_n_out & ext_wr_n_out;
    if (req_valid_in) begin
      cs_acc <= cs_acc & ext_cs_n_out;
      if (!(ext_rd_n_out && ext_wr_n_out)) be_acc <= be_acc & ext_byte_en_n_out;
      if (stb_q && !(ext_rd_n_out && ext_wr_n_out)) nst <= nst + 1;
      if (ext_ale_out) begin
        al_addr <= ext_addr_out;
        al_ad <= ext_ad_out;
      end
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic [23:0] a, input logic w, input logic b, input logic [15:0] d);
    @(negedge core_clk_in);
    cs_acc = 5'h1F;
    be_acc = 2'h3;
    nst = 0;
    cyc = 0;
    {req_addr_in, req_write_in, req_byte_in, req_wdata_in} = {a, w, b, d};
    req_valid_in = 1'b1;
    do begin
      @(negedge core_clk_in);
      cyc++;
    end while (resp_done_out !== 1'b1 && resp_error_out !== 1'b1 && cyc < 400);
    got_err = resp_error_out;
    rdat = resp_rdata_out;
    req_valid_in = 1'b0;
    if (cyc >= 400) chk(cyc, 0);
    for (int k = 0; k < 100 && req_ready_out !== 1'b1; k++) @(negedge core_clk_in);
  endtask
  task t_rw;
    acc(24'h000100, 1'b1, 1'b0, 16'h1234);
    chk(cs_acc, 5'h1E);
    chk(al_addr, 24'h000100);
    acc(24'h000101, 1'b1, 1'b1, 16'hABAB);
    chk(be_acc, 2'h1);
    acc(24'h000100, 1'b0, 1'b0, 16'h0000);
    chk(rdat, 16'hAB34);
  endtask
  task t_win;
    logic [23:0] wa [5];
    logic [4:0] wc [5];
    wa = '{24'h400000, 24'h401000, 24'h500000, 24'h501000, 24'h600000};
    wc = '{5'h1D, 5'h1B, 5'h17, 5'h0F, 5'h1E};
    for (int i = 0; i < 5; i++) begin
      acc(wa[i], 1'b0, 1'b0, 16'h0000);
      chk(cs_acc, wc[i]);
    end
    acc(24'h501002, 1'b1, 1'b0, 16'h5A5A);
    chk(al_addr, 24'h500000);
    chk(al_ad, 16'h1002);
    acc(24'h501002, 1'b0, 1'b0, 16'h0000);
    chk(rdat, 16'h5A5A);
  endtask
  task t_bus8;
    acc(24'h500010, 1'b1, 1'b0, 16'hC3A5);
    chk({nst, be_acc}, {32'h2, 2'h2});
    acc(24'h500010, 1'b0, 1'b0, 16'h0000);
    chk({nst, rdat}, {32'h2, 16'hC3A5});
  endtask
  task t_width;
    addr_width_in = 5'h10;
    acc(24'h600104, 1'b0, 1'b0, 16'h0000);
    chk(al_addr, 24'h000104);
    addr_width_in = 5'h18;
    seg_lines_in = 3'h0;
    acc(24'h600104, 1'b0, 1'b0, 16'h0000);
    chk(al_addr, 24'h000104);
    seg_lines_in = 3'h7;
  endtask
  task t_ready;
    default_function_config_in = 16'h000B;
    acc(24'h600000, 1'b0, 1'b0, 16'h0000);
    t0 = cyc;
    rdy_dly = 4'h5;
    acc(24'h600000, 1'b0, 1'b0, 16'h0000);
    chk(cyc >= t0 + 32, 1);
    default_function_config_in = 16'h000F;
    rdy_hi = 1'b1;
    acc(24'h600000, 1'b0, 1'b0, 16'h0000);
    chk(cyc >= t0 + 32, 1);
    rdy_dly = 4'h0;
    default_function_config_in = 16'h0009;
  endtask
  task t_io;
    acc(24'h600000, 1'b0, 1'b0, 16'h0000);
    t0 = cyc;
    default_timing_config_in = 16'h0014;
    acc(24'h600000, 1'b0, 1'b0, 16'h0000);
    chk(cyc >= t0 + 24, 1);
    default_timing_config_in = 16'h00C4;
    acc(24'h210000, 1'b0, 1'b0, 16'h0000);
    chk(cyc >= t0 + 24, 1);
    default_timing_config_in = 16'h0004;
  endtask
  task t_local;
    single_chip_in = 1'b1;
    acc(24'h400000, 1'b0, 1'b0, 16'h0000);
    chk({got_err, cs_acc}, {1'b1, 5'h1F});
    acc(24'h200010, 1'b0, 1'b0, 16'h0000);
    chk({got_err, cs_acc, rdat}, {1'b0, 5'h1F, 16'h0F1E});
    chk(lpb_addr_out, 24'h200010);
    acc(24'h200020, 1'b1, 1'b0, 16'h7E81);
    chk({got_err, cs_acc, lpb_addr_out, lpb_wdata_out}, {1'b0, 5'h1F, 24'h200020, 16'h7E81});
    single_chip_in = 1'b0;
    acc(24'h20C000, 1'b0, 1'b0, 16'h0000);
    chk(cs_acc, 5'h1E);
  endtask
  task stop_test;
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {nrst_in, single_chip_in, req_valid_in, req_write_in, req_byte_in, rdy_hi} = 6'h00;
    {req_addr_in, req_wdata_in, rdy_dly, lsh} = 47'h0;
    addr_width_in = 5'h18;
    seg_lines_in = 3'h7;
    default_timing_config_in = 16'h0004;
    default_function_config_in = 16'h0009;
    window_timing_config_in = {4{16'h0004}};
    window_function_config_in = {16'h0019, 16'h0001, 16'h0009, 16'h0009};
    window_address_select_in = {16'h5010, 16'h5004, 16'h4010, 16'h4004};
    repeat (3) @(negedge core_clk_in);
    chk({req_ready_out, ext_cs_n_out, ext_rd_n_out, ext_wr_n_out, ext_ale_out,
      bus_reference_clock_out, resp_done_out}, 32'h3F8);
    nrst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk(req_ready_out, 1);
    t_rw;
    t_win;
    t_bus8;
    t_width;
    t_ready;
    t_io;
    t_local;
    stop_test;
  end
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
endmodule
